// ==== pmrbc_top.sv ====
`timescale 1ns/100ps
module pmrbc_top #(
    parameter int NUM_EXT_IRQ = 72,
    parameter logic [12:0] RESET_HOLD_CYC = 13'h0040,
    parameter logic [12:0] MAIN_WAKE_CYC = pmrbc_pkg::MAIN_RESUME_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [pmrbc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ext_reset_n,
    input wire logic wdt_reset_req,
    input wire logic brownout_warn_in,
    input wire logic brownout_reset_in,
    input wire logic rtc_irq,
    input wire logic rtc_alarm,
    input wire logic boot_width_pin_hi,
    input wire logic boot_width_pin_lo,
    input wire logic [NUM_EXT_IRQ-1:0] ext_irq,
    output pmrbc_pkg::pmrbc_gate_t gates,
    output pmrbc_pkg::pmrbc_clkcfg_t clk_cfg,
    output logic chip_reset,
    output logic cpu_run,
    output logic brownout_irq,
    output logic [31:0] boot_fetch_addr,
    output logic [1:0] boot_width,
    output logic unused_addr_gpio,
    output logic cs_swap,
    output pmrbc_pkg::pmrbc_vec_t vector_map
);
    import pmrbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Only the second stage is ever read.
    localparam int NPIN = NUM_EXT_IRQ + 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;

    assign pin_raw = {ext_irq, boot_width_pin_lo, boot_width_pin_hi, rtc_alarm, rtc_irq,
                      brownout_reset_in, brownout_warn_in, ext_reset_n};

    // The reset pin idles high, so both stages start at one for that bit.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_meta <= {{(NPIN-1){1'b0}}, 1'b1};
            pin_sync <= {{(NPIN-1){1'b0}}, 1'b1};
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    logic ext_rst_s;
    logic brownout_warn_s;
    logic brownout_rst_s;
    logic rtc_irq_s;
    logic rtc_alarm_s;
    logic [1:0] boot_pins_s;
    logic ext_irq_any;

    assign ext_rst_s = ~pin_sync[0];
    assign brownout_warn_s = pin_sync[1];
    assign brownout_rst_s = pin_sync[2];
    assign rtc_irq_s = pin_sync[3];
    assign rtc_alarm_s = pin_sync[4];
    assign boot_pins_s = {pin_sync[5], pin_sync[6]};
    assign ext_irq_any = |pin_sync[NPIN-1:7];

    ////////////////////////////////////////////////////////////////////////////////
    // Software state.
    pmrbc_state_t state;
    pmrbc_state_t next_state;
    pmrbc_clkcfg_t cfg;
    pmrbc_vec_t vec_map;
    logic brownout_rst_en;
    logic ext_wake_en;
    logic swap;
    logic [3:0] cause;
    logic [1:0] width;
    logic por_pending;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic [CNT_W-1:0] rst_release;
    logic [CNT_W-1:0] wake_target;

    logic wr_mode;
    logic [1:0] mode_req;
    logic rst_src;
    logic wake_ok;
    logic sw_clear;
    logic low_power_entry;

    assign wr_mode = reg_wr && (reg_addr == OFS_MODE) && (state == ST_RUN);
    assign mode_req = reg_wdata[1:0];
    assign sw_clear = (state == ST_RESET);
    // A brownout reset only counts while software leaves its enable set.
    assign rst_src = ext_rst_s | wdt_reset_req | (brownout_rst_s & brownout_rst_en);
    // Only clockless sources can end Sleep or Power-down.
    assign wake_ok = rtc_irq_s | (ext_irq_any & ext_wake_en);
    assign low_power_entry = (next_state == ST_SLEEP) || (next_state == ST_PDOWN)
                             || (next_state == ST_DPDOWN);
    // Release waits for the RC oscillator to start and then for the fixed hold count.
    assign rst_release = RC_STARTUP_CYC + RESET_HOLD_CYC;

    always_comb begin
        if (cfg.src == SRC_MAIN) begin
            wake_target = MAIN_WAKE_CYC;
        end else if (state == ST_PDOWN) begin
            wake_target = RC_STARTUP_CYC + RC_RESUME_CYC;
        end else begin
            wake_target = RC_RESUME_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (!rst_src && rst_cnt >= rst_release) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_mode) begin
                    case (mode_req)
                        MODE_SLEEP: next_state = ST_SLEEP;
                        MODE_PDOWN: next_state = ST_PDOWN;
                        MODE_DPDOWN: next_state = ST_DPDOWN;
                        default: next_state = ST_RUN;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (wake_ok) begin
                    next_state = ST_WAKE;
                end
            end
            ST_PDOWN: begin
                if (wake_ok) begin
                    next_state = ST_WAKE;
                end
            end
            ST_DPDOWN: begin
                if (rtc_alarm_s) begin
                    next_state = ST_RESET;
                end
            end
            ST_WAKE: begin
                if (wake_cnt <= 13'h0001) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RESET;
        endcase
        // With the regulator off only the reset pin and the RTC alarm are still heard.
        if (state == ST_DPDOWN) begin
            if (ext_rst_s) begin
                next_state = ST_RESET;
            end
        end else if (rst_src) begin
            next_state = ST_RESET;
        end
    end

    // Power-on starts here as well, so a supply return is a normal start-up.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rst_cnt <= '0;
        end else if (state != ST_RESET || rst_src) begin
            rst_cnt <= '0;
        end else if (rst_cnt != {CNT_W{1'b1}}) begin
            rst_cnt <= rst_cnt + 13'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_cnt <= '0;
        end else if (next_state == ST_WAKE && state != ST_WAKE) begin
            wake_cnt <= wake_target;
        end else if (state == ST_WAKE && wake_cnt != '0) begin
            wake_cnt <= wake_cnt - 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock configuration. Hardware only ever clears it; software must rebuild it.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg <= '0;
        end else if (sw_clear) begin
            cfg <= '0;
        end else if (state == ST_RUN && low_power_entry) begin
            cfg.pll_enable <= 1'b0;
            cfg.pll_connect <= 1'b0;
            cfg.cpu_div <= '0;
            cfg.usb_div <= '0;
        end else if (reg_wr && reg_addr == OFS_CLK && state == ST_RUN) begin
            cfg.src <= pmrbc_src_t'(reg_wdata[CLK_SRC_LSB +: 2]);
            cfg.pll_enable <= reg_wdata[CLK_PLL_EN_BIT];
            // Connecting is refused while the PLL is off, so it stays bypassed.
            cfg.pll_connect <= reg_wdata[CLK_PLL_CON_BIT] & cfg.pll_enable;
            cfg.cpu_div <= reg_wdata[CLK_CPU_DIV_LSB +: 8];
            cfg.usb_div <= reg_wdata[CLK_USB_DIV_LSB +: 4];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            brownout_rst_en <= BROWNOUT_RST_EN_RESET;
            ext_wake_en <= EXT_WAKE_EN_RESET;
            vec_map <= VEC_EXT;
        end else if (sw_clear) begin
            brownout_rst_en <= BROWNOUT_RST_EN_RESET;
            ext_wake_en <= EXT_WAKE_EN_RESET;
            vec_map <= VEC_EXT;
        end else if (reg_wr) begin
            if (reg_addr == OFS_RSTCTL) begin
                brownout_rst_en <= reg_wdata[0];
            end
            if (reg_addr == OFS_WAKE) begin
                ext_wake_en <= reg_wdata[0];
            end
            if (reg_addr == OFS_MEMMAP && reg_wdata[1:0] != 2'h3) begin
                vec_map <= pmrbc_vec_t'(reg_wdata[1:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Boot straps are taken once, when the first reset after power-on ends.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            por_pending <= 1'b1;
            width <= 2'h0;
            swap <= 1'b0;
        end else if (por_pending && state == ST_RESET && next_state == ST_RUN) begin
            por_pending <= 1'b0;
            width <= boot_pins_s;
            swap <= 1'b1;
        end else if (reg_wr && reg_addr == OFS_MEMMAP) begin
            swap <= reg_wdata[MAP_SWAP_BIT];
        end
    end

    // Reset causes are sticky; a new cause wins over a write-one clear.
    logic [3:0] cause_set;
    logic [3:0] cause_clr;
    assign cause_set = {brownout_rst_s & brownout_rst_en, 1'b0, wdt_reset_req, ext_rst_s};
    assign cause_clr = (reg_wr && reg_addr == OFS_CAUSE) ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cause <= CAUSE_RESET;
        end else begin
            cause <= (cause & ~cause_clr) | cause_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Gating is decoded from the next state, so it lands on the request edge.
    pmrbc_gate_t next_gates;

    always_comb begin
        next_gates = '{internal_rc_osc_power: 1'b1, internal_rc_osc_out_en: 1'b1,
                       main_osc_en: 1'b0, rtc_osc_en: 1'b1, cpu_clk_en: 1'b1,
                       periph_clk_en: 1'b1, pins_hold: 1'b0, regulator_en: 1'b1};
        next_gates.main_osc_en = (cfg.src == SRC_MAIN) && !low_power_entry;
        case (next_state)
            ST_SLEEP, ST_PDOWN, ST_DPDOWN: begin
                next_gates.internal_rc_osc_out_en = 1'b0;
                next_gates.cpu_clk_en = 1'b0;
                next_gates.periph_clk_en = 1'b0;
                next_gates.pins_hold = 1'b1;
                next_gates.internal_rc_osc_power = (next_state == ST_SLEEP);
                next_gates.regulator_en = (next_state != ST_DPDOWN);
            end
            ST_RESET: begin
                next_gates.main_osc_en = 1'b0;
            end
            default: begin
                next_gates.internal_rc_osc_out_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gates <= '{internal_rc_osc_power: 1'b1, internal_rc_osc_out_en: 1'b1,
                       main_osc_en: 1'b0, rtc_osc_en: 1'b1, cpu_clk_en: 1'b1,
                       periph_clk_en: 1'b1, pins_hold: 1'b0, regulator_en: 1'b1};
            chip_reset <= 1'b1;
            cpu_run <= 1'b0;
            clk_cfg <= '0;
            brownout_irq <= 1'b0;
            boot_width <= 2'h0;
            unused_addr_gpio <= 1'b0;
            cs_swap <= 1'b0;
            vector_map <= VEC_EXT;
            boot_fetch_addr <= BOOT_FETCH_ADDR;
        end else begin
            gates <= next_gates;
            chip_reset <= (next_state == ST_RESET);
            cpu_run <= (next_state == ST_RUN);
            clk_cfg <= cfg;
            brownout_irq <= brownout_warn_s;
            boot_width <= width;
            unused_addr_gpio <= ~por_pending;
            cs_swap <= swap;
            vector_map <= vec_map;
            boot_fetch_addr <= BOOT_FETCH_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port; unmapped addresses read as zero.
    logic [1:0] mode_code;

    always_comb begin
        case (state)
            ST_SLEEP: mode_code = MODE_SLEEP;
            ST_PDOWN: mode_code = MODE_PDOWN;
            ST_DPDOWN: mode_code = MODE_DPDOWN;
            default: mode_code = MODE_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_MODE: reg_rdata <= {30'h0, mode_code};
                OFS_CLK: reg_rdata <= {16'h0000, cfg.usb_div, cfg.cpu_div,
                                       cfg.pll_connect, cfg.pll_enable, cfg.src};
                OFS_STATUS: reg_rdata <= {28'h0, mode_code, state == ST_RUN,
                                          brownout_warn_s};
                OFS_CAUSE: reg_rdata <= {28'h0, cause};
                OFS_RSTCTL: reg_rdata <= {31'h0, brownout_rst_en};
                OFS_MEMMAP: reg_rdata <= {29'h0, swap, vec_map};
                OFS_WAKE: reg_rdata <= {31'h0, ext_wake_en};
                OFS_BOOT: reg_rdata <= {30'h0, width};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

// ==== pmrbc_pkg.sv ====
package pmrbc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the 8-bit register port.
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CLK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CAUSE = 8'h0C;
    localparam logic [7:0] OFS_RSTCTL = 8'h10;
    localparam logic [7:0] OFS_MEMMAP = 8'h14;
    localparam logic [7:0] OFS_WAKE = 8'h18;
    localparam logic [7:0] OFS_BOOT = 8'h1C;

    // Field positions.
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_PLL_EN_BIT = 2;
    localparam int CLK_PLL_CON_BIT = 3;
    localparam int CLK_CPU_DIV_LSB = 4;
    localparam int CLK_USB_DIV_LSB = 12;
    localparam int ST_BROWN_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    localparam int ST_MODE_LSB = 2;
    localparam int CAUSE_EXT_BIT = 0;
    localparam int CAUSE_WDT_BIT = 1;
    localparam int CAUSE_POR_BIT = 2;
    localparam int CAUSE_BROWNOUT_BIT = 3;
    localparam int MAP_SWAP_BIT = 2;

    // Reset values.
    localparam logic BROWNOUT_RST_EN_RESET = 1'b1;
    localparam logic EXT_WAKE_EN_RESET = 1'b0;
    localparam logic [3:0] CAUSE_RESET = 4'h4;
    localparam logic [31:0] BOOT_FETCH_ADDR = 32'h8100_0000;

    // Timing at a 100 ns reference clock.
    localparam int CNT_W = 13;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RC_STARTUP_NS = 60000;
    localparam int RC_STARTUP_CYC_I = (RC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] RC_STARTUP_CYC = RC_STARTUP_CYC_I[CNT_W-1:0];
    localparam logic [CNT_W-1:0] RC_RESUME_CYC = 13'h0004;
    localparam logic [CNT_W-1:0] MAIN_RESUME_CYC = 13'h1000;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        MODE_RUN = 2'h0, MODE_SLEEP = 2'h1, MODE_PDOWN = 2'h2, MODE_DPDOWN = 2'h3
    } pmrbc_mode_t;
    typedef enum logic [1:0] {
        SRC_INTERNAL_RC_OSC = 2'h0, SRC_MAIN = 2'h1, SRC_RTC = 2'h2
    } pmrbc_src_t;
    typedef enum logic [1:0] {
        VEC_BOOT_ROM = 2'h0, VEC_SRAM = 2'h1, VEC_EXT = 2'h2
    } pmrbc_vec_t;
    typedef enum logic [5:0] {
        ST_RESET = 6'h01, ST_RUN = 6'h02, ST_SLEEP = 6'h04,
        ST_PDOWN = 6'h08, ST_DPDOWN = 6'h10, ST_WAKE = 6'h20
    } pmrbc_state_t;

    typedef struct packed {
        logic internal_rc_osc_power;
        logic internal_rc_osc_out_en;
        logic main_osc_en;
        logic rtc_osc_en;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic pins_hold;
        logic regulator_en;
    } pmrbc_gate_t;

    typedef struct packed {
        pmrbc_src_t src;
        logic pll_enable;
        logic pll_connect;
        logic [7:0] cpu_div;
        logic [3:0] usb_div;
    } pmrbc_clkcfg_t;

endpackage

// ==== pmrbc_asserts.sv ====
`timescale 1ns/100ps
module pmrbc_asserts (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [pmrbc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic ext_reset_n,
    input wire logic wdt_reset_req,
    input wire logic brownout_warn_in,
    input wire pmrbc_pkg::pmrbc_gate_t gates,
    input wire pmrbc_pkg::pmrbc_clkcfg_t clk_cfg,
    input wire logic chip_reset,
    input wire logic cpu_run,
    input wire logic brownout_irq,
    input wire logic [31:0] boot_fetch_addr
);
    import pmrbc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode requests only count while the core runs; the design ignores them otherwise.
    logic mode_wr;
    logic slp;
    logic pdn;
    logic dpd;
    assign mode_wr = reg_wr && reg_addr == OFS_MODE && cpu_run && !chip_reset;
    assign slp = mode_wr && reg_wdata[1:0] == 2'h1;
    assign pdn = mode_wr && reg_wdata[1:0] == 2'h2;
    assign dpd = mode_wr && reg_wdata[1:0] == 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    a_sleep_gates: assert property (
        slp |=> !gates.cpu_clk_en && !gates.periph_clk_en && gates.pins_hold && !gates.main_osc_en)
        else $error("sleep gating wrong");
    a_rc_osc_kept: assert property (
        slp |=> !gates.internal_rc_osc_out_en && gates.internal_rc_osc_power && gates.rtc_osc_en)
        else $error("sleep oscillator state wrong");
    a_pll_cleared: assert property (
        slp || pdn |=> ##1 {clk_cfg.pll_enable, clk_cfg.pll_connect, clk_cfg.cpu_div,
        clk_cfg.usb_div} == 14'h0)
        else $error("pll or dividers not cleared");
    a_pdown_rc_off: assert property (
        pdn |=> !gates.internal_rc_osc_power && !gates.internal_rc_osc_out_en
        && !gates.cpu_clk_en)
        else $error("power-down left rc oscillator on");
    a_deep_reg: assert property (dpd |=> !gates.regulator_en)
        else $error("regulator still on");
    a_boot_addr: assert property (boot_fetch_addr == BOOT_FETCH_ADDR)
        else $error("boot address wrong");
    a_reset_stall: assert property (chip_reset |-> !cpu_run)
        else $error("running during reset");
    a_wdt_reset: assert property (
        wdt_reset_req && !chip_reset |-> ##[1:3] chip_reset)
        else $error("watchdog did not reset");
    a_pin_reset: assert property ((!ext_reset_n) [*5] |-> chip_reset)
        else $error("reset pin not honoured");
    a_bod_warn: assert property ($rose(brownout_warn_in) |-> ##[1:5] brownout_irq)
        else $error("brownout request missing");
    a_rc_after_reset: assert property (
        $fell(chip_reset) |-> clk_cfg.src == SRC_INTERNAL_RC_OSC && !clk_cfg.pll_enable
        && !clk_cfg.pll_connect)
        else $error("clock not on rc oscillator after reset");

    c_sleep: cover property (slp);
    c_pdown: cover property (pdn);
    c_release: cover property ($fell(chip_reset));
endmodule

bind pmrbc_top pmrbc_asserts u_asserts (
    .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .ext_reset_n, .wdt_reset_req,
    .brownout_warn_in, .gates, .clk_cfg, .chip_reset, .cpu_run, .brownout_irq, .boot_fetch_addr
);

// ==== pmrbc_supply_model.sv ====
`timescale 1ns/100ps
module pmrbc_supply_model (
    input wire logic ref_clk,
    output logic ext_reset_n,
    output logic wdt_reset_req,
    output logic brownout_warn_in,
    output logic brownout_reset_in,
    output logic rtc_irq,
    output logic rtc_alarm,
    output logic boot_width_pin_hi,
    output logic boot_width_pin_lo
);
    int vdd_mv = 3300;
    initial begin
        ext_reset_n = 1'b1;
        wdt_reset_req = 1'b0;
        rtc_irq = 1'b0;
        rtc_alarm = 1'b0;
    end
    // Straps are wired on the board, so they never move during a run.
    assign boot_width_pin_hi = 1'b1;
    assign boot_width_pin_lo = 1'b0;
    // The reset comparator stays asserted all the way down, so only the level matters here.
    assign brownout_warn_in = vdd_mv < 2950;
    assign brownout_reset_in = vdd_mv < 2650;

    ////////////////////////////////////////////////////////////////////////////////
    // Source 0 reset pin, 1 watchdog, 2 rtc interrupt, 3 rtc alarm, 4 deep sag, 5 mild sag.
    task automatic fault(input int k, input logic on);
        @(posedge ref_clk);
        case (k)
            0: ext_reset_n <= !on;
            1: wdt_reset_req <= on;
            2: rtc_irq <= on;
            3: rtc_alarm <= on;
            4: vdd_mv <= on ? 2600 : 3300;
            default: vdd_mv <= on ? 2900 : 3300;
        endcase
    endtask
endmodule

// ==== pmrbc_top_tb.sv ====
`timescale 1ns/100ps
module pmrbc_top_tb;
    import pmrbc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [71:0] ext_irq = '0;
    logic [31:0] reg_rdata, boot_fetch_addr;
    logic ext_reset_n, wdt_reset_req, brownout_warn_in, brownout_reset_in, rtc_irq, rtc_alarm;
    logic boot_width_pin_hi, boot_width_pin_lo, chip_reset, cpu_run, brownout_irq;
    logic unused_addr_gpio, cs_swap;
    logic [1:0] boot_width;
    pmrbc_gate_t gates;
    pmrbc_clkcfg_t clk_cfg;
    pmrbc_vec_t vector_map;
    int n_fail = 0;
    int samples_checked = 0;

    always #50 ref_clk = ~ref_clk;

    // A short hold and main-oscillator count keep every reset and wake inside a short run.
    pmrbc_top #(.NUM_EXT_IRQ(72), .RESET_HOLD_CYC(13'h0004), .MAIN_WAKE_CYC(13'h0008)) uut (
        .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_reset_n,
        .wdt_reset_req, .brownout_warn_in, .brownout_reset_in, .rtc_irq, .rtc_alarm,
        .boot_width_pin_hi, .boot_width_pin_lo, .ext_irq, .gates, .clk_cfg, .chip_reset,
        .cpu_run, .brownout_irq, .boot_fetch_addr, .boot_width, .unused_addr_gpio, .cs_swap,
        .vector_map);
    pmrbc_supply_model env (
        .ref_clk, .ext_reset_n, .wdt_reset_req, .brownout_warn_in, .brownout_reset_in,
        .rtc_irq, .rtc_alarm, .boot_width_pin_hi, .boot_width_pin_lo);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Cycles until execution resumes must fall inside the window lo..hi.
    task automatic wake_chk(input int lo, input int hi);
        int n;
        for (n = 1; n <= 5000 && cpu_run !== 1'b1; n++) begin
            cyc(1);
        end
        if (n > 5000) begin
            n_fail++;
            wrap_up();
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        wake_chk(604, 612);
        // Straps and swap are registered one cycle after the run flag rises.
        cyc(1);
        chk(boot_fetch_addr, BOOT_FETCH_ADDR);
        chk(boot_width, 32'h2);
        chk(unused_addr_gpio, 32'h1);
        chk(cs_swap, 32'h1);
        chk(vector_map, VEC_EXT);
        chk(clk_cfg, 32'h0);
        rchk(OFS_CAUSE, 32'h4);
        rchk(OFS_BOOT, 32'h2);
        rchk(8'h40, 32'h0);
    endtask
    task automatic t_sleep(input pmrbc_src_t src, input int lo, input int hi);
        wr(OFS_CLK, 32'h0000_3054 | src);
        wr(OFS_MODE, 32'h1);
        chk(gates, 32'h93);
        cyc(1);
        chk(clk_cfg, {src, 14'h0});
        env.fault(2, 1'b1);
        wake_chk(lo, hi);
        env.fault(2, 1'b0);
        wr(OFS_CLK, 32'h0000_3054 | src);
        cyc(2);
        chk(clk_cfg, {src, 14'h2053});
    endtask
    task automatic t_pdown;
        wr(OFS_CLK, 32'h0);
        wr(OFS_WAKE, 32'h1);
        wr(OFS_MODE, 32'h2);
        chk(gates, 32'h13);
        @(posedge ref_clk);
        ext_irq[40] <= 1'b1;
        wake_chk(604, 612);
        @(posedge ref_clk);
        ext_irq <= '0;
        wr(OFS_WAKE, 32'h0);
    endtask
    task automatic t_deep;
        wr(OFS_MEMMAP, 32'h5);
        cyc(1);
        chk(vector_map, VEC_SRAM);
        wr(OFS_MODE, 32'h3);
        chk(gates.regulator_en, 32'h0);
        env.fault(2, 1'b1);
        cyc(20);
        chk(cpu_run, 32'h0);
        env.fault(2, 1'b0);
        env.fault(3, 1'b1);
        cyc(8);
        chk(chip_reset, 32'h1);
        env.fault(3, 1'b0);
        wake_chk(560, 615);
        chk(vector_map, VEC_EXT);
    endtask
    task automatic t_reset(input int k, input logic [31:0] cause);
        wr(OFS_CAUSE, 32'hF);
        env.fault(k, 1'b1);
        cyc(700);
        chk(chip_reset, 32'h1);
        env.fault(k, 1'b0);
        wake_chk(600, 615);
        rchk(OFS_CAUSE, cause);
    endtask
    task automatic t_brown;
        env.fault(5, 1'b1);
        cyc(5);
        chk(brownout_irq, 32'h1);
        rchk(OFS_STATUS, 32'h3);
        env.fault(5, 1'b0);
        wr(OFS_RSTCTL, 32'h0);
        env.fault(4, 1'b1);
        cyc(10);
        chk(chip_reset, 32'h0);
        env.fault(4, 1'b0);
        cyc(5);
        chk(brownout_irq, 32'h0);
        wr(OFS_RSTCTL, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_boot();
        t_sleep(SRC_INTERNAL_RC_OSC, 4, 10);
        t_sleep(SRC_MAIN, 8, 14);
        t_pdown();
        t_deep();
        t_brown();
        t_reset(0, 32'h1);
        t_reset(1, 32'h2);
        t_reset(4, 32'h8);
        wrap_up();
    end
endmodule
